// ---- lhpfd_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer; out side is fed from flops only
module lhpfd_buf2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	logic             hold_valid;
	logic [WIDTH-1:0] hold_data;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////
	// ready drops only when both slots hold a word
	assign in_ready = ~hold_valid;
	assign push     = in_valid & ~hold_valid;
	assign pop      = out_valid & out_ready;

	// slot occupancy
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			out_valid  <= 1'b0;
			hold_valid <= 1'b0;
		end else if (push && !pop) begin
			out_valid  <= 1'b1;
			hold_valid <= out_valid;
		end else if (pop && !push) begin
			out_valid  <= hold_valid;
			hold_valid <= 1'b0;
		end
	end

	// slot data; no reset needed since valid guards it
	always_ff @(posedge clk) begin
		if (push && !pop) begin
			if (out_valid) begin
				hold_data <= in_data;
			end else begin
				out_data <= in_data;
			end
		end else if (pop && !push) begin
			out_data <= hold_data;
		end else if (pop && push) begin
			if (hold_valid) begin
				out_data  <= hold_data;
				hold_data <= in_data;
			end else begin
				out_data <= in_data;
			end
		end
	end

endmodule

`default_nettype wire

// ---- lhpfd_core.sv ----
// How it works
// - write-only divider register, resets zero, reserved zero
// - frame rate is subclock over ratio times N
// - codes 0..6 give ratio 2..128, 7 banned
// - data register reaches memory at X,Y address
// - writes go straight in, reads latch first
// - memory and data register not initialised
// - one-eighth or one-sixteenth duty, 40 by 16
// - display runs on subclock, memory kept in standby
// - select low hits pointer, high hits register
// - read/write line low writes, high reads
// - access happens at each strobe falling edge
// - both lines low loads pointer from bus
// - pointer kept until rewritten
// - select high, write low loads pointed register
// - only data register is readable
// - data read turns bus out, drives memory byte
// - read data held until next strobe fall
// - read/write low releases bus, clears output
// - bus direction set by read/write line only; here the bus also needs select high and the pointer on the data register
// - low three pointer bits pick five registers
// - address steps after data access per increment
`timescale 1ns/1ps
`default_nettype none

module lhpfd_core (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire lhpfd_pkg::lhpfd_host_t   host_ctrl,
	input  wire logic [7:0]               host_data_in,
	output logic      [7:0]               host_data_out,
	output logic                          host_data_oe,
	input  wire logic                     subclock_en,
	output logic                          frame_tick,
	output logic                          duty_eighth,
	output logic                          module_standby,
	output logic                          display_on,
	output logic                          supply_to_divider,
	output logic                          bleeder_enable,
	output lhpfd_pkg::lhpfd_scan_t        scan_data,
	output logic                          scan_valid,
	input  wire logic                     scan_ready
);
	import lhpfd_pkg::*;

	logic       strobe_s1;
	logic       strobe_s2;
	logic       strobe_s3;
	logic       strobe_fall;
	logic       rs;
	logic       rw;
	logic [7:0] register_pointer;
	logic [2:0] ptr;
	logic       idx_wr;
	logic       reg_wr;
	logic       data_rd;
	logic       data_wr;
	logic       step;
	logic       read_modify_write;
	logic       increment_x;
	logic [2:0] column_byte_address;
	logic [3:0] row_address;
	logic [2:0] next_col;
	logic [3:0] next_row;
	logic [3:0] y_max;
	logic [7:0] mem [0:MEM_DEPTH-1];
	logic [7:0] mem_rd;
	logic [7:0] display_data_port;
	logic [2:0] frame_divider_code;
	logic [2:0] code_eff;
	logic [3:0] frame_shift;
	logic [11:0] frame_limit;
	logic [11:0] frame_cnt;
	logic       scan_active;
	logic [2:0] scan_col;
	logic [3:0] scan_row;
	logic       scan_push_valid;
	logic       scan_push_ready;
	lhpfd_scan_t scan_word;

	////////////////////////////////////////////////////////////////////////
	// strobe synchroniser; s1 feeds only s2, the edge is seen on s2/s3
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strobe_s1 <= 1'b0;
			strobe_s2 <= 1'b0;
			strobe_s3 <= 1'b0;
		end else begin
			strobe_s1 <= host_ctrl.access_strobe;
			strobe_s2 <= strobe_s1;
			strobe_s3 <= strobe_s2;
		end
	end

	// the host keeps rs and rw still around the fall, so sampling them
	// two cycles late in the detected edge cycle is safe
	assign strobe_fall = strobe_s3 & ~strobe_s2;
	assign rs          = host_ctrl.register_select_line;
	assign rw          = host_ctrl.read_write_line;
	assign ptr         = register_pointer[2:0];

	// access decode: select picks pointer or register, rw picks direction
	assign idx_wr  = strobe_fall & ~rs & ~rw;
	assign reg_wr  = strobe_fall & rs & ~rw;
	assign data_rd = strobe_fall & rs & rw & (ptr == IDX_DATA);
	assign data_wr = reg_wr & (ptr == IDX_DATA);
	assign step    = data_wr | (data_rd & ~read_modify_write);

	////////////////////////////////////////////////////////////////////////
	// pointer holds until the next pointer write
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			register_pointer <= POINTER_RST;
		end else if (idx_wr) begin
			register_pointer <= host_data_in;
		end
	end

	// control 1: standby and duty
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			module_standby <= CTRL1_RST[CTRL1_STANDBY_BIT];
			duty_eighth    <= CTRL1_RST[CTRL1_DUTY8_BIT];
		end else if (reg_wr && ptr == IDX_CTRL1) begin
			module_standby <= host_data_in[CTRL1_STANDBY_BIT];
			duty_eighth    <= host_data_in[CTRL1_DUTY8_BIT];
		end
	end

	// control 2; entering standby drops display, supply and bleeder bits,
	// everything else (memory too) is left as it was
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			display_on        <= CTRL2_RST[CTRL2_DISP_BIT];
			supply_to_divider <= CTRL2_RST[CTRL2_SUPPLY_BIT];
			bleeder_enable    <= CTRL2_RST[CTRL2_BLEEDER_BIT];
			read_modify_write <= CTRL2_RST[CTRL2_RMW_BIT];
			increment_x       <= CTRL2_RST[CTRL2_INC_BIT];
		end else if (reg_wr && ptr == IDX_CTRL1
				&& host_data_in[CTRL1_STANDBY_BIT]) begin
			display_on        <= 1'b0;
			supply_to_divider <= 1'b0;
			bleeder_enable    <= 1'b0;
		end else if (reg_wr && ptr == IDX_CTRL2) begin
			display_on        <= host_data_in[CTRL2_DISP_BIT];
			supply_to_divider <= host_data_in[CTRL2_SUPPLY_BIT];
			bleeder_enable    <= host_data_in[CTRL2_BLEEDER_BIT];
			read_modify_write <= host_data_in[CTRL2_RMW_BIT];
			increment_x       <= host_data_in[CTRL2_INC_BIT];
		end
	end

	// frame divider code; reserved upper bits are simply not stored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			frame_divider_code <= FRAME_RST[FRAME_CODE_LSB +: 3];
		end else if (reg_wr && ptr == IDX_FRAME) begin
			frame_divider_code <= host_data_in[FRAME_CODE_LSB +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address stepping: chosen axis counts, wraps, carries into the other
	assign y_max = duty_eighth ? Y_MAX_8 : Y_MAX_16;

	always_comb begin
		next_col = column_byte_address;
		next_row = row_address;
		if (!increment_x) begin
			if (row_address >= y_max) begin
				next_row = 4'h0;
				next_col = (column_byte_address >= X_MAX) ? 3'h0
					: 3'(column_byte_address + 3'h1);
			end else begin
				next_row = 4'(row_address + 4'h1);
			end
		end else begin
			if (column_byte_address >= X_MAX) begin
				next_col = 3'h0;
				next_row = (row_address >= y_max) ? 4'h0
					: 4'(row_address + 4'h1);
			end else begin
				next_col = 3'(column_byte_address + 3'h1);
			end
		end
	end

	// address register; a write to it and a step cannot meet
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			column_byte_address <= ADDR_RST[ADDR_COL_LSB +: 3];
			row_address         <= ADDR_RST[ADDR_ROW_LSB +: 4];
		end else if (reg_wr && ptr == IDX_ADDR) begin
			column_byte_address <= host_data_in[ADDR_COL_LSB +: 3];
			row_address         <= host_data_in[ADDR_ROW_LSB +: 4];
		end else if (step) begin
			column_byte_address <= next_col;
			row_address         <= next_row;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// display memory; columns past the last are ignored, not aliased
	assign mem_rd = (column_byte_address <= X_MAX)
		? mem[{column_byte_address, row_address}] : 8'h00;

	// no reset: contents stay undefined until written, kept in standby
	always_ff @(posedge clk) begin
		if (data_wr && column_byte_address <= X_MAX) begin
			mem[{column_byte_address, row_address}] <= host_data_in;
		end
	end

	// data register: last byte moved either way, never reset
	always_ff @(posedge clk) begin
		if (data_rd) begin
			display_data_port <= mem_rd;
		end else if (data_wr) begin
			display_data_port <= host_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus driven only while rw and rs are high with the pointer on data; output cleared while rw is low
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			host_data_oe <= 1'b0;
		end else begin
			host_data_oe <= rw & rs & (ptr == IDX_DATA);
		end
	end

	// read data is held until the next data read or until rw drops; other reads give nothing
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			host_data_out <= 8'h00;
		end else if (!rw) begin
			host_data_out <= 8'h00;
		end else if (data_rd) begin
			host_data_out <= mem_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame divider: count subclock pulses to ratio times N; the banned
	// code is clamped to the slowest ratio rather than left undefined
	assign code_eff    = (frame_divider_code > FRAME_CODE_MAX)
		? FRAME_CODE_MAX : frame_divider_code;
	assign frame_shift = 4'(code_eff) + (duty_eighth ? SHIFT_DUTY8
		: SHIFT_DUTY16);
	assign frame_limit = FRAME_ONE << frame_shift;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			frame_cnt  <= 12'h000;
			frame_tick <= 1'b0;
		end else if (subclock_en) begin
			if (frame_cnt >= 12'(frame_limit - FRAME_ONE)) begin
				frame_cnt  <= 12'h000;
				frame_tick <= 1'b1;
			end else begin
				frame_cnt  <= 12'(frame_cnt + FRAME_ONE);
				frame_tick <= 1'b0;
			end
		end else begin
			frame_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// display scan: one pass per frame, host writes win the memory port
	assign scan_push_valid = scan_active & display_on & ~module_standby
		& ~data_wr;
	assign scan_word.row   = scan_row;
	assign scan_word.col   = scan_col;
	assign scan_word.bits  = mem[{scan_col, scan_row}];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			scan_active <= 1'b0;
			scan_col    <= 3'h0;
			scan_row    <= 4'h0;
		end else if (frame_tick) begin
			scan_active <= 1'b1;
			scan_col    <= 3'h0;
			scan_row    <= 4'h0;
		end else if (scan_push_valid && scan_push_ready) begin
			if (scan_col >= X_MAX) begin
				scan_col <= 3'h0;
				if (scan_row >= y_max) begin
					scan_row    <= 4'h0;
					scan_active <= 1'b0;
				end else begin
					scan_row <= 4'(scan_row + 4'h1);
				end
			end else begin
				scan_col <= 3'(scan_col + 3'h1);
			end
		end
	end

	// a stalled receiver fills the buffer, which then holds the scan
	lhpfd_buf2 #(
		.WIDTH (SCAN_W)
	) u_scan_buf (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (scan_push_valid),
		.in_ready  (scan_push_ready),
		.in_data   (scan_word),
		.out_valid (scan_valid),
		.out_ready (scan_ready),
		.out_data  (scan_data)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_pointer_load: assert property (@(posedge clk) disable iff (!reset_n)
		idx_wr |=> register_pointer == $past(host_data_in))
		else $error("pointer did not load bus byte");

	chk_pointer_keep: assert property (@(posedge clk) disable iff (!reset_n)
		!idx_wr |=> $stable(register_pointer))
		else $error("pointer changed without a pointer write");

	chk_bus_release: assert property (@(posedge clk) disable iff (!reset_n)
		!rw |=> !host_data_oe && host_data_out == 8'h00)
		else $error("bus not released after rw low");

	chk_read_drive: assert property (@(posedge clk) disable iff (!reset_n)
		data_rd |=> host_data_oe && host_data_out == $past(mem_rd)
		&& display_data_port == host_data_out)
		else $error("read data not driven");

	chk_read_hold: assert property (@(posedge clk) disable iff (!reset_n)
		host_data_oe && rw && !data_rd |=> $stable(host_data_out))
		else $error("read data not held");

	chk_no_ctrl_read: assert property (@(posedge clk) disable iff (!reset_n)
		strobe_fall && rs && rw && ptr != IDX_DATA
		|=> !host_data_oe && $stable(host_data_out))
		else $error("write-only register answered a read");

	chk_divider_load: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && ptr == IDX_FRAME
		|=> frame_divider_code == $past(host_data_in[2:0]))
		else $error("divider code not loaded");

	chk_frame_tick: assert property (@(posedge clk) disable iff (!reset_n)
		subclock_en && frame_cnt == 12'(frame_limit - FRAME_ONE)
		|=> frame_tick ##1 !frame_tick)
		else $error("frame tick missing at divider end");

	chk_addr_step: assert property (@(posedge clk) disable iff (!reset_n)
		data_wr && !increment_x && row_address < y_max
		|=> row_address == $past(row_address) + 4'h1
		&& $stable(column_byte_address))
		else $error("row address did not step");

	chk_rmw_hold: assert property (@(posedge clk) disable iff (!reset_n)
		data_rd && read_modify_write
		|=> $stable(row_address) && $stable(column_byte_address))
		else $error("address moved on a read-modify-write read");

	chk_standby_off: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && ptr == IDX_CTRL1 && host_data_in[CTRL1_STANDBY_BIT]
		|=> !display_on && !supply_to_divider && !bleeder_enable)
		else $error("standby did not drop display bits");

	chk_mem_write: assert property (@(posedge clk) disable iff (!reset_n)
		data_wr && column_byte_address <= X_MAX
		|=> mem[$past({column_byte_address, row_address})]
		== $past(host_data_in))
		else $error("display memory write lost");

endmodule

`default_nettype wire

// ---- lhpfd_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module lhpfd_core_tb;
	import lhpfd_pkg::*;
	logic        clk, reset_n, subclock_en, scan_ready, stall, rdy;
	logic        oe, frame_tick, duty_eighth, module_standby, display_on;
	logic        supply_to_divider, bleeder_enable, scan_valid;
	logic [7:0]  bus, dout, q, v;
	logic [6:0]  a;
	lhpfd_host_t host_ctrl;
	lhpfd_scan_t scan_data, held;
	logic [7:0]  mem [0:MEM_DEPTH-1];
	int          fail_count, checks, seed, i, n, c;

	lhpfd_core dut_u (.clk(clk), .reset_n(reset_n), .host_ctrl(host_ctrl),
		.host_data_in(bus), .host_data_out(dout), .host_data_oe(oe),
		.subclock_en(subclock_en), .frame_tick(frame_tick),
		.duty_eighth(duty_eighth), .module_standby(module_standby),
		.display_on(display_on), .supply_to_divider(supply_to_divider),
		.bleeder_enable(bleeder_enable), .scan_data(scan_data),
		.scan_valid(scan_valid), .scan_ready(scan_ready));

	lhpfd_host_model host_u (.clk(clk), .dev_out(dout), .dev_oe(oe),
		.host_ctrl(host_ctrl), .bus_level(bus));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// slow clock pulses every other cycle; receiver stalls at random;
	// a word is checked here, half a cycle before the edge that takes it,
	// so the design's own flops are never raced at the rising edge
	always @(negedge clk) begin
		rdy = stall ? 1'b0 : 1'($random(seed));
		if (reset_n && scan_valid && rdy
		    && mem[{scan_data.col, scan_data.row}] !== 8'hxx)
			check(16'(scan_data.bits),
			      16'(mem[{scan_data.col, scan_data.row}]));
		subclock_en <= reset_n ? ~subclock_en : 1'b0;
		scan_ready  <= rdy;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// address stepping after a data access, row or column first
	function automatic logic [6:0] step(input logic [6:0] p, input logic inc,
	                                   input logic d8);
		logic [3:0] ym;
		ym = d8 ? Y_MAX_8 : Y_MAX_16;
		if (!inc)
			step = (p[3:0] == ym) ? {(p[6:4] == X_MAX) ? 3'h0 : p[6:4] + 3'h1,
			                         4'h0} : {p[6:4], p[3:0] + 4'h1};
		else
			step = (p[6:4] == X_MAX) ? {3'h0, (p[3:0] == ym) ? 4'h0
			                         : p[3:0] + 4'h1} : {p[6:4] + 3'h1, p[3:0]};
	endfunction

	task automatic wreg(input logic [2:0] idx, input logic [7:0] val);
		host_u.access(1'b0, 1'b0, {5'h00, idx}, q);
		host_u.access(1'b1, 1'b0, val, q);
	endtask

	// cycles between two frame ticks, bounded both ways
	task automatic tick_gap(output int g);
		int k;
		for (k = 0; k < 5000 && frame_tick !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		for (g = 1; g < 5000 && frame_tick !== 1'b1; g++) @(negedge clk);
		if (k >= 5000 || g >= 5000) begin
			fail_count++;
			complete_run();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hc7a7;
		fail_count = 0;
		checks = 0;
		stall = 1'b0;
		reset_n = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk) reset_n = 1'b1;
		check({oe, dout, frame_tick, duty_eighth, module_standby, display_on,
		       supply_to_divider, bleeder_enable, scan_valid}, 16'h0);
		$display("test reset done");

		// pointer held across repeated writes; standby clears display bits
		wreg(IDX_CTRL2, 8'h70);
		check({display_on, supply_to_divider, bleeder_enable}, 16'h7);
		host_u.access(1'b1, 1'b0, 8'h40, q);
		check({display_on, supply_to_divider, bleeder_enable}, 16'h4);
		wreg(IDX_CTRL1, 8'h22);
		check({module_standby, duty_eighth, display_on}, 16'h6);
		host_u.access(1'b1, 1'b0, 8'h00, q);
		check({module_standby, duty_eighth}, 16'h0);
		$display("test registers done");

		// fill memory row first, read back column first from a random spot
		wreg(IDX_ADDR, 8'h00);
		host_u.access(1'b0, 1'b0, {5'h00, IDX_DATA}, q);
		for (i = 0; i < MEM_DEPTH; i++) begin
			mem[i] = 8'($random(seed));
			host_u.access(1'b1, 1'b0, mem[i], q);
		end
		n = $unsigned($random(seed)) % MEM_DEPTH;
		a = {3'(n / 16), 4'(n % 16)};
		wreg(IDX_CTRL2, 8'h02);
		wreg(IDX_ADDR, {a[6:4], 1'b0, a[3:0]});
		host_u.access(1'b0, 1'b0, {5'h00, IDX_DATA}, q);
		for (i = 0; i < MEM_DEPTH; i++) begin
			host_u.access(1'b1, 1'b1, 8'h00, q);
			check(16'(q), 16'(mem[a]));
			a = step(a, 1'b1, 1'b0);
		end
		v = dout;
		repeat (3) @(negedge clk);
		check({oe, dout}, {8'h01, v});
		host_u.lines(1'b1, 1'b0, 8'h00);
		repeat (2) @(negedge clk);
		check({oe, dout}, 16'h0);
		$display("test memory done");

		// read-modify-write: reads stay put, the write steps the row
		wreg(IDX_CTRL2, 8'h08);
		wreg(IDX_ADDR, {a[6:4], 1'b0, a[3:0]});
		host_u.access(1'b0, 1'b0, {5'h00, IDX_DATA}, q);
		repeat (2) begin
			host_u.access(1'b1, 1'b1, 8'h00, q);
			check(16'(q), 16'(mem[a]));
		end
		mem[a] = ~mem[a];
		host_u.access(1'b1, 1'b0, mem[a], q);
		a = step(a, 1'b0, 1'b0);
		host_u.access(1'b1, 1'b1, 8'h00, q);
		check(16'(q), 16'(mem[a]));
		host_u.access(1'b0, 1'b0, {5'h00, IDX_CTRL2}, q);
		host_u.access(1'b1, 1'b1, 8'h00, q);
		check({oe, q}, 16'h0);
		$display("test rmw done");

		// legal codes 0..6 at 1/8 duty, then two at 1/16; code 7 is banned
		wreg(IDX_CTRL2, 8'h40);
		wreg(IDX_CTRL1, 8'h02);
		for (i = 0; i < 9; i++) begin
			n = (i < 7) ? i : i - 7;
			if (i == 7)
				wreg(IDX_CTRL1, 8'h00);
			wreg(IDX_FRAME, 8'(n));
			tick_gap(c);
			tick_gap(c);
			check(16'(c), 16'(4 * (1 << n) * (i < 7 ? 8 : 16)));
			if (i == 0) begin
				stall = 1'b1;
				repeat (2) @(negedge clk);
				for (c = 0; c < 600 && scan_valid !== 1'b1; c++) @(negedge clk);
				if (c >= 600) begin
					fail_count++;
					complete_run();
				end
				held = scan_data;
				repeat (20) @(negedge clk);
				check({scan_valid, scan_data}, {1'b1, held});
				stall = 1'b0;
			end
		end
		$display("test divider done");
		complete_run();
	end
endmodule

`default_nettype wire

// ---- lhpfd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// host cpu model: drives the control lines and the data port
module lhpfd_host_model (
	input  wire logic              clk,
	input  wire logic [7:0]        dev_out,
	input  wire logic              dev_oe,
	output lhpfd_pkg::lhpfd_host_t host_ctrl,
	output logic      [7:0]        bus_level
);
	import lhpfd_pkg::*;
	logic       drv;
	logic [7:0] val;
	logic [7:0] last;

	// select and read lines preset high so no pointer write can slip
	initial begin
		host_ctrl = '1;
		drv = 1'b0;
		val = 8'h00;
		last = 8'h00;
	end

	// a released bus never keeps its last level; it shows the inverse
	always @(posedge clk) last <= bus_level;
	assign bus_level = dev_oe ? dev_out : (drv ? val : ~last);

	// port goes to input before a read, to output a cycle after rw drops for a write
	task automatic lines(input logic rs, input logic rw, input logic [7:0] d);
		@(negedge clk);
		host_ctrl.register_select_line = rs;
		if (rw) begin
			drv = 1'b0;
			host_ctrl.read_write_line = 1'b1;
		end else begin
			host_ctrl.read_write_line = 1'b0;
			@(negedge clk);
			val = d;
			drv = 1'b1;
		end
	endtask

	// one strobe fall; lines held well past the fall
	task automatic access(input logic rs, input logic rw,
	                      input logic [7:0] d, output logic [7:0] q);
		lines(rs, rw, d);
		repeat (2) @(negedge clk);
		host_ctrl.access_strobe = 1'b0;
		repeat (7) @(negedge clk);
		q = dev_out;
		host_ctrl.access_strobe = 1'b1;
		@(negedge clk);
	endtask
endmodule

`default_nettype wire

// ---- lhpfd_pkg.sv ----
package lhpfd_pkg;

////////////////////////////////////////////////////////////////////////////////
// register pointer values, low three bits of the pointer
localparam logic [2:0] IDX_CTRL1 = 3'h0;
localparam logic [2:0] IDX_CTRL2 = 3'h1;
localparam logic [2:0] IDX_ADDR  = 3'h2;
localparam logic [2:0] IDX_FRAME = 3'h3;
localparam logic [2:0] IDX_DATA  = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// field positions
localparam int CTRL1_STANDBY_BIT = 5;
localparam int CTRL1_DUTY8_BIT   = 1;
localparam int CTRL2_DISP_BIT    = 6;
localparam int CTRL2_SUPPLY_BIT  = 5;
localparam int CTRL2_BLEEDER_BIT = 4;
localparam int CTRL2_RMW_BIT     = 3;
localparam int CTRL2_INC_BIT     = 1;
localparam int ADDR_COL_LSB      = 5;
localparam int ADDR_ROW_LSB      = 0;
localparam int FRAME_CODE_LSB    = 0;

////////////////////////////////////////////////////////////////////////////////
// reset values
localparam logic [7:0] CTRL1_RST   = 8'h00;
localparam logic [7:0] CTRL2_RST   = 8'h00;
localparam logic [7:0] ADDR_RST    = 8'h00;
localparam logic [7:0] FRAME_RST   = 8'h00;
localparam logic [7:0] POINTER_RST = 8'h00;

////////////////////////////////////////////////////////////////////////////////
// display memory shape and frame divider
localparam logic [2:0]  X_MAX          = 3'h4;
localparam logic [3:0]  Y_MAX_16       = 4'hf;
localparam logic [3:0]  Y_MAX_8        = 4'h7;
localparam int          MEM_DEPTH      = 80;
localparam logic [2:0]  FRAME_CODE_MAX = 3'h6;
localparam logic [3:0]  SHIFT_DUTY8    = 4'h4;
localparam logic [3:0]  SHIFT_DUTY16   = 4'h5;
localparam logic [11:0] FRAME_ONE      = 12'h001;

////////////////////////////////////////////////////////////////////////////////
// carriers
typedef struct packed {
	logic register_select_line;
	logic read_write_line;
	logic access_strobe;
} lhpfd_host_t;

typedef struct packed {
	logic [3:0] row;
	logic [2:0] col;
	logic [7:0] bits;
} lhpfd_scan_t;

localparam int SCAN_W = $bits(lhpfd_scan_t);

endpackage
